// file: pkg/ebpi_params.svh
// Constants for the external bus pin interface.
// Included by the package and the core; definitions only.
`ifndef EBPI_PARAMS_SVH
`define EBPI_PARAMS_SVH
`define EBPI_HALF_W        8
`define EBPI_PORT_W        16
`define EBPI_ALE_CYCLES    4'h1
`define EBPI_ADDR_CYCLES   4'h1
`define EBPI_DATA_CYCLES   4'h2
`define EBPI_CFG_RESET     16'h0000
`define EBPI_DIR_RESET     8'h00
`endif

// file: pkg/ebpi_pkg.sv
// Types for the external bus pin interface.
// Assumes ebpi_params.svh is on the include path.
`include "ebpi_params.svh"
package ebpi_pkg;
	// Bus mode as set by software
	typedef enum logic [1:0] {
		EBPI_DEMUX8  = 2'h0,
		EBPI_DEMUX16 = 2'h1,
		EBPI_MUX8    = 2'h2,
		EBPI_MUX16   = 2'h3
	} ebpi_mode_t;
	// Access sequencer states, one-hot
	typedef enum logic [4:0] {
		EBPI_IDLE = 5'h01,
		EBPI_ALE  = 5'h02,
		EBPI_ADDR = 5'h04,
		EBPI_DATA = 5'h08,
		EBPI_WAIT = 5'h10
	} ebpi_state_t;
endpackage : ebpi_pkg

// file: core/ebpi_half_port.sv
// One 8-bit half of a bidirectional port: per-bit direction and output mux.
// Assumes the caller selects bus or general I/O use per half.
`timescale 1ns/1ps
`default_nettype none
`include "ebpi_params.svh"
module ebpi_half_port #(
	parameter int W = `EBPI_HALF_W
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Bus overlay
	input  wire logic         bus_own,
	input  wire logic         bus_oe,
	input  wire logic [W-1:0] bus_out,
	// General I/O
	input  wire logic [W-1:0] gpio_dir,
	input  wire logic [W-1:0] gpio_out,
	// Pin side
	output logic      [W-1:0] pin_o,
	output logic      [W-1:0] pin_oe
);
	// Registered so the top outputs come straight from flops
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					pin_o[i]  <= 1'b0;
					pin_oe[i] <= 1'b0;
				end else begin
					// Driver off whenever the bit is an input
					pin_o[i]  <= bus_own ? bus_out[i] : gpio_out[i];
					pin_oe[i] <= bus_own ? bus_oe : gpio_dir[i];
				end
			end
		end
	endgenerate
endmodule : ebpi_half_port
`default_nettype wire

// file: core/ebpi_core.sv
// External bus pin interface: access sequencer and pin muxing.
// Assumes requests come from the CPU side, one at a time, synchronous to CLOCK.
`timescale 1ns/1ps
`default_nettype none
`include "ebpi_params.svh"
module ebpi_core (
	// Clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RESET_N,
	// Configuration
	input  wire logic [1:0]  BUS_MODE,
	input  wire logic        WAIT_ENABLE,
	input  wire logic        WRITE_STROBE_CONFIG,
	input  wire logic [15:0] SHARED_BUS_DIR,
	input  wire logic [15:0] SHARED_BUS_GPIO_OUT,
	input  wire logic [15:0] DEMUX_ADDRESS_GPIO_OUT,
	input  wire logic [15:0] DEMUX_ADDRESS_DIR,
	// Access request
	input  wire logic        REQ,
	input  wire logic        REQ_WRITE,
	input  wire logic        REQ_HIGH_BYTE,
	input  wire logic        REQ_LOW_BYTE,
	input  wire logic [15:0] REQ_ADDR,
	input  wire logic [15:0] REQ_WDATA,
	output logic             ACK,
	output logic [15:0]      RDATA,
	// Pins
	input  wire logic        WAIT_IN,
	input  wire logic        EXTERNAL_FETCH_SELECT_N,
	output logic             ADDR_LATCH_STROBE,
	output logic             READ_STROBE_N,
	output logic             WRITE_STROBE_N,
	input  wire logic [15:0] SHARED_BUS_PORT_I,
	output logic [15:0]      SHARED_BUS_PORT_O,
	output logic [15:0]      SHARED_BUS_PORT_OE,
	output logic [15:0]      DEMUX_ADDRESS_PORT_O,
	output logic [15:0]      DEMUX_ADDRESS_PORT_OE,
	// Reset-sampled status
	output logic             BOOT_EXTERNAL,
	output logic [15:0]      RESET_CONFIG
);
	ebpi_pkg::ebpi_state_t state_reg;
	ebpi_pkg::ebpi_state_t state_next;
	logic [3:0]  cnt_reg;
	logic        wr_reg;
	logic        hi_reg;
	logic        lo_reg;
	logic [15:0] addr_reg;
	logic [15:0] wdata_reg;
	logic        mux_reg;
	logic        w16_reg;
	logic        demux_seen_reg;
	logic        cfg_done_reg;

	// Mode decode used in several places
	function automatic logic is_mux(input logic [1:0] m);
		is_mux = (m == ebpi_pkg::EBPI_MUX8) || (m == ebpi_pkg::EBPI_MUX16);
	endfunction
	function automatic logic is_w16(input logic [1:0] m);
		is_w16 = (m == ebpi_pkg::EBPI_DEMUX16) || (m == ebpi_pkg::EBPI_MUX16);
	endfunction

	wire logic mode_mux = is_mux(BUS_MODE);
	wire logic mode_w16 = is_w16(BUS_MODE);

	// Sequencer next state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ebpi_pkg::EBPI_IDLE: begin
				if (REQ)
					state_next = mode_mux ? ebpi_pkg::EBPI_ALE : ebpi_pkg::EBPI_DATA;
			end
			ebpi_pkg::EBPI_ALE: begin
				if (cnt_reg == 4'h0)
					state_next = ebpi_pkg::EBPI_ADDR;
			end
			ebpi_pkg::EBPI_ADDR: begin
				if (cnt_reg == 4'h0)
					state_next = ebpi_pkg::EBPI_DATA;
			end
			ebpi_pkg::EBPI_DATA: begin
				if (cnt_reg == 4'h0)
					state_next = (WAIT_ENABLE && WAIT_IN) ? ebpi_pkg::EBPI_WAIT : ebpi_pkg::EBPI_IDLE;
			end
			ebpi_pkg::EBPI_WAIT: begin
				// Stretch until the wait input falls
				if (!WAIT_IN)
					state_next = ebpi_pkg::EBPI_IDLE;
			end
		endcase
	end

	// State, phase counter and latched request
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_reg <= ebpi_pkg::EBPI_IDLE;
			cnt_reg   <= 4'h0;
			wr_reg    <= 1'b0;
			hi_reg    <= 1'b0;
			lo_reg    <= 1'b0;
			addr_reg  <= 16'h0000;
			wdata_reg <= 16'h0000;
			mux_reg   <= 1'b0;
			w16_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_reg != state_next) begin
				unique case (state_next)
					ebpi_pkg::EBPI_ALE:  cnt_reg <= `EBPI_ALE_CYCLES - 4'h1;
					ebpi_pkg::EBPI_ADDR: cnt_reg <= `EBPI_ADDR_CYCLES - 4'h1;
					ebpi_pkg::EBPI_DATA: cnt_reg <= `EBPI_DATA_CYCLES - 4'h1;
					ebpi_pkg::EBPI_IDLE,
					ebpi_pkg::EBPI_WAIT: cnt_reg <= 4'h0;
				endcase
			end else if (cnt_reg != 4'h0) begin
				cnt_reg <= cnt_reg - 4'h1;
			end
			// Mode frozen per access so a mid-access switch cannot tear it
			if (state_reg == ebpi_pkg::EBPI_IDLE && REQ) begin
				wr_reg    <= REQ_WRITE;
				hi_reg    <= REQ_HIGH_BYTE;
				lo_reg    <= REQ_LOW_BYTE;
				addr_reg  <= REQ_ADDR;
				wdata_reg <= REQ_WDATA;
				mux_reg   <= mode_mux;
				w16_reg   <= mode_w16;
			end
		end
	end

	wire logic in_bus   = (state_reg != ebpi_pkg::EBPI_IDLE);
	wire logic in_data  = (state_reg == ebpi_pkg::EBPI_DATA) || (state_reg == ebpi_pkg::EBPI_WAIT);
	wire logic finish   = in_data && (state_next == ebpi_pkg::EBPI_IDLE);
	wire logic addr_ph  = (state_next == ebpi_pkg::EBPI_ALE) || (state_next == ebpi_pkg::EBPI_ADDR);
	wire logic data_nx  = (state_next == ebpi_pkg::EBPI_DATA) || (state_next == ebpi_pkg::EBPI_WAIT);

	// Strobes, registered against next state so pins change with the phase
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			ADDR_LATCH_STROBE <= 1'b0;
			READ_STROBE_N     <= 1'b1;
			WRITE_STROBE_N    <= 1'b1;
		end else begin
			// One pulse per multiplexed access while address is out
			ADDR_LATCH_STROBE <= (state_next == ebpi_pkg::EBPI_ALE);
			READ_STROBE_N     <= !(data_nx && !wr_reg_n());
			// Low-byte mode: only low-byte writes on 16-bit, all on 8-bit
			WRITE_STROBE_N    <= !(data_nx && wr_reg_n() &&
				(!WRITE_STROBE_CONFIG || !w16_n() || lo_n()));
		end
	end

	// Request fields as seen on the cycle the strobe is computed
	function automatic logic wr_reg_n();
		wr_reg_n = (state_reg == ebpi_pkg::EBPI_IDLE) ? REQ_WRITE : wr_reg;
	endfunction
	function automatic logic w16_n();
		w16_n = (state_reg == ebpi_pkg::EBPI_IDLE) ? mode_w16 : w16_reg;
	endfunction
	function automatic logic lo_n();
		lo_n = (state_reg == ebpi_pkg::EBPI_IDLE) ? REQ_LOW_BYTE : lo_reg;
	endfunction

	// Completion and read capture
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			ACK   <= 1'b0;
			RDATA <= 16'h0000;
		end else begin
			ACK <= finish;
			if (finish && !wr_reg)
				RDATA <= w16_reg ? SHARED_BUS_PORT_I : {8'h00, SHARED_BUS_PORT_I[7:0]};
		end
	end

	// Remember demux use so the address port keeps the address afterwards
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N)
			demux_seen_reg <= 1'b0;
		else if (!mode_mux)
			demux_seen_reg <= 1'b1;
	end

	// Shared port overlay per half
	logic        lo_own;
	logic        hi_own;
	logic        bus_oe_lo;
	logic        bus_oe_hi;
	logic [15:0] bus_val;
	logic [15:0] addr_cur;
	logic [15:0] wdata_cur;
	always_comb begin
		// Held in variables so halves can be selected from them
		addr_cur  = addr_c();
		wdata_cur = wdata_c();
		lo_own    = in_bus || (state_next != ebpi_pkg::EBPI_IDLE);
		// 8-bit demux leaves the high half as general I/O
		hi_own    = lo_own && (mux_reg_c() || w16_c());
		bus_oe_lo = addr_ph || (data_nx && wr_reg_n());
		// 8-bit mux keeps address on the high half all access long
		bus_oe_hi = (mux_reg_c() && !w16_c()) ? 1'b1 : bus_oe_lo;
		if (addr_ph)
			bus_val = addr_cur;
		else if (mux_reg_c() && !w16_c())
			bus_val = {addr_cur[15:8], wdata_cur[7:0]};
		else
			bus_val = wdata_cur;
	end
	function automatic logic mux_reg_c();
		mux_reg_c = (state_reg == ebpi_pkg::EBPI_IDLE) ? mode_mux : mux_reg;
	endfunction
	function automatic logic w16_c();
		w16_c = w16_n();
	endfunction
	function automatic logic [15:0] addr_c();
		addr_c = (state_reg == ebpi_pkg::EBPI_IDLE) ? REQ_ADDR : addr_reg;
	endfunction
	function automatic logic [15:0] wdata_c();
		wdata_c = (state_reg == ebpi_pkg::EBPI_IDLE) ? REQ_WDATA : wdata_reg;
	endfunction

	// Shared port halves
	ebpi_half_port #(.W(`EBPI_HALF_W)) u_shared_lo (
		.clk      (CLOCK),
		.rst_n    (RESET_N),
		.bus_own  (lo_own),
		.bus_oe   (bus_oe_lo),
		.bus_out  (bus_val[7:0]),
		.gpio_dir (SHARED_BUS_DIR[7:0]),
		.gpio_out (SHARED_BUS_GPIO_OUT[7:0]),
		.pin_o    (SHARED_BUS_PORT_O[7:0]),
		.pin_oe   (SHARED_BUS_PORT_OE[7:0])
	);
	ebpi_half_port #(.W(`EBPI_HALF_W)) u_shared_hi (
		.clk      (CLOCK),
		.rst_n    (RESET_N),
		.bus_own  (hi_own),
		.bus_oe   (bus_oe_hi),
		.bus_out  (bus_val[15:8]),
		.gpio_dir (SHARED_BUS_DIR[15:8]),
		.gpio_out (SHARED_BUS_GPIO_OUT[15:8]),
		.pin_o    (SHARED_BUS_PORT_O[15:8]),
		.pin_oe   (SHARED_BUS_PORT_OE[15:8])
	);

	// Address port: demux modes, or mux after a demux mode was used
	wire logic addr_own = !mode_mux || demux_seen_reg;
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			DEMUX_ADDRESS_PORT_O  <= 16'h0000;
			DEMUX_ADDRESS_PORT_OE <= 16'h0000;
		end else begin
			DEMUX_ADDRESS_PORT_O  <= addr_own ? addr_c() : DEMUX_ADDRESS_GPIO_OUT;
			DEMUX_ADDRESS_PORT_OE <= addr_own ? 16'hFFFF : DEMUX_ADDRESS_DIR;
		end
	end

	// Boot source caught at the first edge after release; configuration too, only when fetch is external
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			cfg_done_reg  <= 1'b0;
			BOOT_EXTERNAL <= 1'b0;
			RESET_CONFIG  <= `EBPI_CFG_RESET;
		end else if (!cfg_done_reg) begin
			cfg_done_reg  <= 1'b1;
			BOOT_EXTERNAL <= !EXTERNAL_FETCH_SELECT_N;
			if (!EXTERNAL_FETCH_SELECT_N)
				RESET_CONFIG <= SHARED_BUS_PORT_I;
		end
	end

	// Checks
	sequence mux_start_s;
		(state_reg == ebpi_pkg::EBPI_IDLE) && REQ && mode_mux;
	endsequence
	ale_pulse_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		mux_start_s |=> ADDR_LATCH_STROBE ##1 !ADDR_LATCH_STROBE)
		else $error("latch strobe not one pulse");
	wait_hold_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(state_reg == ebpi_pkg::EBPI_WAIT) && WAIT_IN |=> !ACK)
		else $error("access ended while wait held");
	rd_strobe_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		ACK && !wr_reg |-> $past(!READ_STROBE_N))
		else $error("read without strobe");
	wr_low_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		!WRITE_STROBE_N && WRITE_STROBE_CONFIG && w16_reg && in_data |-> lo_reg)
		else $error("write strobe on high byte");
	addr_port_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		!mode_mux |=> DEMUX_ADDRESS_PORT_OE == 16'hFFFF)
		else $error("address port not driven");
	gpio_dir_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		!lo_own && !in_bus |=> SHARED_BUS_PORT_OE[7:0] == $past(SHARED_BUS_DIR[7:0]))
		else $error("driver ignores direction");
	boot_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		$rose(cfg_done_reg) |-> BOOT_EXTERNAL == !$past(EXTERNAL_FETCH_SELECT_N))
		else $error("boot source wrong");
	no_ale_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(state_reg == ebpi_pkg::EBPI_IDLE) && REQ && !mode_mux |=> !ADDR_LATCH_STROBE)
		else $error("latch strobe in demux");
endmodule : ebpi_core
`default_nettype wire

// file: bench/ebpi_mem_model.sv
// Far-side memory model: latches the address, stores writes, answers reads.
// Assumes the bench passes the bus mode, the wait length and the reset pattern.
`timescale 1ns/1ps
`default_nettype none
module ebpi_mem_model (
	// Pins of the device
	input  wire logic        clk,
	input  wire logic        ale,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic [15:0] o,
	input  wire logic [15:0] oe,
	input  wire logic [15:0] addr_port,
	// Bench controls
	input  wire logic        mux,
	input  wire logic [2:0]  waits,
	input  wire logic        cfg_en,
	input  wire logic [15:0] cfg,
	// Resolved pins
	output logic             wait_in,
	output logic [15:0]      pins
);
	logic [15:0] mem [256];
	logic [7:0]  a_reg;
	logic [15:0] last_reg;
	logic [2:0]  w_reg;
	logic [15:0] drv;
	logic [7:0]  idx;
	logic        strobe;
	assign strobe = !rd_n || !wr_n;
	assign idx = mux ? a_reg : addr_port[7:0];
	// Latch, store, and count down the wait span
	always_ff @(posedge clk) begin
		if (mux && ale) a_reg <= pins[7:0];
		if (!wr_n) mem[idx] <= pins;
		w_reg <= strobe ? ((w_reg == 3'h0) ? 3'h0 : w_reg - 3'h1) : waits;
		last_reg <= pins;
	end
	// Wait held high for a set number of strobe cycles
	assign wait_in = strobe && (w_reg != 3'h0);
	// Released lines toggle so a stale value never passes for data
	assign drv = cfg_en ? cfg : (!rd_n ? mem[idx] : ~last_reg);
	assign pins = (oe & o) | (~oe & drv);
endmodule : ebpi_mem_model
`default_nettype wire

// file: bench/ebpi_core_tb.sv
// Self-checking bench for the bus pin interface core.
// Assumes the memory model file is compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ebpi_params.svh"
module ebpi_core_tb;
	logic CLOCK, RESET_N, WAIT_ENABLE, WRITE_STROBE_CONFIG, REQ, REQ_WRITE, REQ_HIGH_BYTE, REQ_LOW_BYTE;
	logic ACK, WAIT_IN, EXTERNAL_FETCH_SELECT_N, ADDR_LATCH_STROBE, READ_STROBE_N, WRITE_STROBE_N, BOOT_EXTERNAL;
	logic [1:0] BUS_MODE;
	logic [15:0] SHARED_BUS_DIR, SHARED_BUS_GPIO_OUT, DEMUX_ADDRESS_GPIO_OUT, DEMUX_ADDRESS_DIR, REQ_ADDR, REQ_WDATA;
	logic [15:0] RDATA, SHARED_BUS_PORT_I, SHARED_BUS_PORT_O, SHARED_BUS_PORT_OE, DEMUX_ADDRESS_PORT_O;
	logic [15:0] DEMUX_ADDRESS_PORT_OE, RESET_CONFIG, cfg, a, d;
	logic [2:0]  waits;
	logic        cfg_en, demux_seen, lo;
	logic [15:0] shadow [int];
	int          fails, check_count;
	ebpi_core ebpi_core_inst (.CLOCK, .RESET_N, .BUS_MODE, .WAIT_ENABLE, .WRITE_STROBE_CONFIG, .SHARED_BUS_DIR,
		.SHARED_BUS_GPIO_OUT, .DEMUX_ADDRESS_GPIO_OUT, .DEMUX_ADDRESS_DIR, .REQ, .REQ_WRITE, .REQ_HIGH_BYTE,
		.REQ_LOW_BYTE, .REQ_ADDR, .REQ_WDATA, .ACK, .RDATA, .WAIT_IN, .EXTERNAL_FETCH_SELECT_N, .ADDR_LATCH_STROBE,
		.READ_STROBE_N, .WRITE_STROBE_N, .SHARED_BUS_PORT_I, .SHARED_BUS_PORT_O, .SHARED_BUS_PORT_OE,
		.DEMUX_ADDRESS_PORT_O, .DEMUX_ADDRESS_PORT_OE, .BOOT_EXTERNAL, .RESET_CONFIG);
	ebpi_mem_model ebpi_mem_model_inst (.clk(CLOCK), .ale(ADDR_LATCH_STROBE), .rd_n(READ_STROBE_N),
		.wr_n(WRITE_STROBE_N), .o(SHARED_BUS_PORT_O), .oe(SHARED_BUS_PORT_OE), .addr_port(DEMUX_ADDRESS_PORT_O),
		.mux(BUS_MODE[1]), .waits, .cfg_en, .cfg, .wait_in(WAIT_IN), .pins(SHARED_BUS_PORT_I));
	// Clock, 100 ns period
	initial begin
		CLOCK = 1'b0;
		forever #50 CLOCK = ~CLOCK;
	end
	// Compare and count
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Cycles from the taking edge to the answer, counted inclusive, no waits
	function automatic int exp_cycles(logic m);
		exp_cycles = int'(`EBPI_DATA_CYCLES) + 1;
		if (m) exp_cycles += int'(`EBPI_ALE_CYCLES) + int'(`EBPI_ADDR_CYCLES);
	endfunction : exp_cycles
	// Write strobe due under the chosen strobe mode
	function automatic logic wr_expected(logic w, logic low_mode, logic bus8, logic low);
		wr_expected = w && (!low_mode || bus8 || low);
	endfunction : wr_expected
	// Verdict and end of run
	task automatic results();
		$display("Checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : results
	// Reset with a given boot select; config pattern driven on the data port
	task automatic do_reset(logic sel);
		RESET_N = 1'b0;
		BUS_MODE = 2'h2;
		EXTERNAL_FETCH_SELECT_N = sel;
		cfg = 16'($urandom);
		cfg_en = 1'b1;
		demux_seen = 1'b0;
		repeat (8) @(negedge CLOCK);
		check("rd_rst", READ_STROBE_N, 16'h0001);
		check("oe_rst", SHARED_BUS_PORT_OE, 16'h0000);
		RESET_N = 1'b1;
		@(negedge CLOCK);
		cfg_en = 1'b0;
		check("boot", BOOT_EXTERNAL, 16'(!sel));
		if (!sel) check("cfg", RESET_CONFIG, cfg);
		else check("cfg_int", RESET_CONFIG, `EBPI_CFG_RESET);
	endtask : do_reset
	// One access; watches the pins until the answer
	task automatic access(logic w, logic hi);
		int n, ales, rds, wrs, base;
		logic m, b8, ext, wexp;
		m = BUS_MODE[1];
		b8 = !BUS_MODE[0];
		n = 0;
		ales = 0;
		rds = 0;
		wrs = 0;
		base = exp_cycles(m);
		@(negedge CLOCK);
		{REQ_WRITE, REQ_ADDR, REQ_WDATA, REQ_LOW_BYTE, REQ_HIGH_BYTE, REQ} = {w, a, d, lo, hi, 1'b1};
		// First sample follows the taking edge, where the latch strobe rises in the mux modes
		do begin
			@(posedge CLOCK);
			#1;
			n++;
			if (ADDR_LATCH_STROBE) ales++;
			if (ADDR_LATCH_STROBE) check("ale_addr", SHARED_BUS_PORT_O[7:0], a[7:0]);
			rds += !READ_STROBE_N;
			wrs += !WRITE_STROBE_N;
			if (m && b8 && !READ_STROBE_N) check("a_high", SHARED_BUS_PORT_O[15:8], a[15:8]);
			if (demux_seen && !READ_STROBE_N) check("aport", DEMUX_ADDRESS_PORT_O, a);
			check("aport_oe", DEMUX_ADDRESS_PORT_OE, (demux_seen || !m) ? 16'hFFFF : DEMUX_ADDRESS_DIR);
			if (!m && !b8 && !WRITE_STROBE_N) check("wdata", SHARED_BUS_PORT_O, d);
			if (!m && b8) check("io_oe", SHARED_BUS_PORT_OE[15:8], SHARED_BUS_DIR[15:8]);
			if (!m && b8) check("io_o", SHARED_BUS_PORT_O[15:8] & SHARED_BUS_DIR[15:8],
				SHARED_BUS_GPIO_OUT[15:8] & SHARED_BUS_DIR[15:8]);
		end while (!ACK && n < 40);
		@(negedge CLOCK);
		REQ = 1'b0;
		wexp = wr_expected(w, WRITE_STROBE_CONFIG, b8, lo);
		// The far side holds wait only while a strobe is out
		ext = WAIT_ENABLE && waits != 3'h0 && (!w || wexp);
		if (ext) check("lat_wait", 16'(n > base && n < base + 6), 16'h0001);
		else check("lat", 16'(n), 16'(base));
		if (m) check("ale_cnt", 16'(ales), 16'h0001);
		check("rd_seen", 16'(rds != 0), 16'(!w));
		check("wr_seen", 16'(wrs != 0), 16'(wexp));
		if (wexp) shadow[a[7:0]] = b8 ? {8'h00, d[7:0]} : d;
		if (!w && shadow.exists(a[7:0])) check("rdata", RDATA, shadow[a[7:0]]);
	endtask : access
	// Main sequence: mux first, then demux, then mux again on the sticky address port
	initial begin
		logic [1:0] modes [6];
		modes = '{2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3};
		{REQ, REQ_WRITE, REQ_HIGH_BYTE, REQ_LOW_BYTE, REQ_ADDR, REQ_WDATA} = '0;
		{WAIT_ENABLE, WRITE_STROBE_CONFIG, waits, lo, a, d} = '0;
		{SHARED_BUS_DIR, SHARED_BUS_GPIO_OUT, DEMUX_ADDRESS_GPIO_OUT, DEMUX_ADDRESS_DIR} = '0;
		fails = 0;
		check_count = 0;
		void'($urandom(32'hDD7C19C0));
		do_reset(1'b0);
		for (int i = 0; i < 6; i++) begin
			@(negedge CLOCK);
			BUS_MODE = modes[i];
			{WAIT_ENABLE, WRITE_STROBE_CONFIG} = 2'($urandom);
			{SHARED_BUS_DIR, SHARED_BUS_GPIO_OUT} = $urandom;
			{DEMUX_ADDRESS_GPIO_OUT, DEMUX_ADDRESS_DIR} = $urandom;
			if (!modes[i][1]) demux_seen = 1'b1;
			shadow.delete();
			for (int j = 0; j < 12; j++) begin
				a = 16'($urandom);
				d = (j == 1) ? 16'hFFFF : 16'($urandom);
				waits = ($urandom % 2) ? 3'h3 : 3'h0;
				lo = (j < 2) ? 1'b1 : 1'($urandom);
				access(1'b1, !lo || j < 2);
				access(1'b0, 1'b1);
			end
		end
		do_reset(1'b1);
		results();
	end
	// Watchdog
	initial begin
		#2000000;
		fails++;
		results();
	end
endmodule : ebpi_core_tb
`default_nettype wire
